// File: rtl/gate_drive_map.svh
`ifndef GATE_DRIVE_MAP_SVH
`define GATE_DRIVE_MAP_SVH
// input mode encodings
`define MODE_SIX 2'h0
`define MODE_THREE 2'h1
`define MODE_SINGLE 2'h2
// per-phase drive encodings inside the commutation table
`define DRV_OFF 2'h0
`define DRV_HIGH 2'h1
`define DRV_LOW 2'h2
// table entry layout: phase a bits 1:0, b bits 3:2, c bits 5:4
`define TBL_WIDTH 6
`define PH_A_LSB 0
`define PH_B_LSB 2
`define PH_C_LSB 4
// charge pump thresholds in millivolts
`define PUMP_TRIPLER_MIN_MV 16'h1130
`define PUMP_TRIPLER_MAX_MV 16'h4650
// fault cause bit positions
`define FLT_OC_BIT 0
`define FLT_PUMP_UV_BIT 1
`define FLT_PUMP_OV_BIT 2
`define FLT_SHOOT_BIT 3
`define FLT_WIDTH 4
`endif

// File: rtl/gate_drive_pkg.sv
package gate_drive_pkg;
  typedef enum logic [1:0] {mode_six_type_v, mode_three_type_v, mode_single_type_v}
    mode_type;
  typedef enum {run_state, dwell_state} seq_state_type;
endpackage

// File: rtl/gate_drive_pwm_mode_decoder.sv
`timescale 1ns/1ps
`include "gate_drive_map.svh"
// Functional notes
// - six-input mode drives each gate from its own pwm input.
// - three-input mode derives each low side as complement of its high input.
// - three-input mode ignores all three low-side input pins.
// - single-pwm mode takes pwm on phase a high, code on three pins.
// - single-pwm mode accepts any duty from zero to full.
// - 3-bit code selects one of eight drive states incl align and stop.
// - table outputs honour user control settings.
// - after dwell-marked change, hold dwell until phase c high goes low.
// - single-pwm mode always ignores phase c low input.
// - active or diode freewheeling table chosen by a setting.
// - any fault drives fault pin low; cause bits readable.
// - overcurrent flagged per fet separately.
// - high and low side of a phase never on together.
// - pump tripler from 4.4 V to 18 V, doubler above.
// - pump monitored for undervoltage and overvoltage.
// - high gate may stay on continuously for full duty.
module gate_drive_pwm_mode_decoder
  import gate_drive_pkg::*;
#(
  parameter int unsigned TW = `TBL_WIDTH
) (
  // clock and asynchronous reset
  input wire logic clk,
  input wire logic rst,
  // controller pins, asynchronous to clk
  input wire logic phase_a_high_in,
  input wire logic phase_a_low_in,
  input wire logic phase_b_high_in,
  input wire logic phase_b_low_in,
  input wire logic phase_c_high_in,
  input wire logic phase_c_low_in,
  // configuration, same clock domain
  input wire logic [1:0] mode_cfg,
  input wire logic diode_freewheel_cfg,
  input wire logic gate_enable_cfg,
  input wire logic [8*TW-1:0] active_table_cfg,
  input wire logic [8*TW-1:0] diode_table_cfg,
  // analog monitor flags, asynchronous to clk
  input wire logic [5:0] vds_overcurrent_in,
  input wire logic pump_uv_in,
  input wire logic pump_ov_in,
  input wire logic [15:0] supply_mv,
  input wire logic fault_clear,
  // gate commands, bit 0 is phase a
  output logic [2:0] high_gate_out,
  output logic [2:0] low_gate_out,
  // open-drain fault pin and sticky status
  output logic fault_out_n,
  output logic fault_out_oe_n,
  output logic [`FLT_WIDTH-1:0] fault_cause,
  output logic [5:0] overcurrent_status,
  // pump regime and sequencer status
  output logic pump_tripler,
  output logic [2:0] phase_state,
  output logic dwell_active,
  output logic [1:0] mode_status
);
  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, change accepted when stages 2 and 3 agree
  // the agree filter also rejects a pin that toggles every cycle, so a
  // noisy unused pin holds its last settled level instead of chattering.
  // only the second stage reads the first, so metastability stays contained.
  // monitor flags use the same filter; bit 6 of that chain is a spare.
  logic [5:0] pins;
  logic [5:0] s1_reg, s2_reg, s3_reg, clean_reg;
  logic [5:0] s1_next, s2_next, s3_next, clean_next;
  logic [8:0] st1_reg, st2_reg, st3_reg, sclean_reg;
  logic [8:0] st1_next, st2_next, st3_next, sclean_next;
  logic [8:0] stat_pins;
  assign pins = {phase_c_low_in, phase_c_high_in, phase_b_low_in, phase_b_high_in,
                 phase_a_low_in, phase_a_high_in};
  assign stat_pins = {pump_ov_in, pump_uv_in, 1'b0, vds_overcurrent_in};
  // next values of synchroniser chains
  always_comb begin
    s1_next = pins;
    s2_next = s1_reg;
    s3_next = s2_reg;
    clean_next = clean_reg;
    st1_next = stat_pins;
    st2_next = st1_reg;
    st3_next = st2_reg;
    sclean_next = sclean_reg;
    for (int i = 0; i < 6; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        clean_next[i] = s3_reg[i];
      end
    end
    for (int i = 0; i < 9; i++) begin
      if (st2_reg[i] == st3_reg[i]) begin
        sclean_next[i] = st3_reg[i];
      end
    end
  end
  // synchroniser registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_reg <= 6'h00;
      s2_reg <= 6'h00;
      s3_reg <= 6'h00;
      clean_reg <= 6'h00;
      st1_reg <= 9'h000;
      st2_reg <= 9'h000;
      st3_reg <= 9'h000;
      sclean_reg <= 9'h000;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
      clean_reg <= clean_next;
      st1_reg <= st1_next;
      st2_reg <= st2_next;
      st3_reg <= st3_next;
      sclean_reg <= sclean_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // table lookup helper, used for both tables
  // each table holds eight entries of TW bits, entry k at bits k*TW upward;
  // within an entry each phase has a two-bit drive field.
  function automatic logic [TW-1:0] entry(input logic [8*TW-1:0] tbl, input logic [2:0] idx);
    entry = tbl[idx*TW +: TW];
  endfunction

  // per-phase decode of a two-bit drive field into high and low
  function automatic logic [1:0] drive_of(input logic [1:0] fld);
    case (fld)
      `DRV_HIGH: drive_of = 2'h2;
      `DRV_LOW: drive_of = 2'h1;
      default: drive_of = 2'h0;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // mode, code and dwell sequencing
  // the phase code is taken from the filtered pins; a code change seen while
  // the dwell pin is high parks the sequencer in dwell until that pin drops.
  // the latched code still tracks the pins during dwell.
  logic [1:0] mode_reg, mode_next;
  logic dwell_reg, dwell_next;
  logic [2:0] code_reg, code_next;
  logic [2:0] live_code;
  seq_state_type seq_reg, seq_next;
  assign live_code = {clean_reg[3], clean_reg[2], clean_reg[1]};
  always_comb begin
    mode_next = mode_cfg;
    code_next = code_reg;
    seq_next = seq_reg;
    case (seq_reg)
      run_state: begin
        if (live_code != code_reg) begin
          code_next = live_code;
          if (clean_reg[4]) begin
            seq_next = dwell_state;
          end
        end
      end
      dwell_state: begin
        code_next = live_code;
        if (!clean_reg[4]) begin
          seq_next = run_state;
        end
      end
      default: seq_next = run_state;
    endcase
    dwell_next = (seq_next == dwell_state);
  end
  // mode and sequencer registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_reg <= `MODE_SIX;
      code_reg <= 3'h0;
      seq_reg <= run_state;
      dwell_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      code_reg <= code_next;
      seq_reg <= seq_next;
      dwell_reg <= dwell_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // gate command generation
  // mode 3 is unused and keeps every gate off.
  // pump faults and the enable setting override every mode.
  // the handshake stage adds one all-off cycle whenever a phase swaps sides,
  // so the two fets of a half-bridge never overlap even for one clock.
  logic [`FLT_WIDTH-1:0] fault_cause_reg, fault_cause_next, fault_set;
  logic [2:0] hi_reg, lo_reg, hi_next, lo_next;
  logic [TW-1:0] ent;
  logic [2:0] hcmd, lcmd;
  logic pwm;
  logic [1:0] d;
  always_comb begin
    hcmd = 3'h0;
    lcmd = 3'h0;
    pwm = clean_reg[0];
    ent = diode_freewheel_cfg ? entry(diode_table_cfg, code_reg)
                              : entry(active_table_cfg, code_reg);
    d = 2'h0;
    case (mode_reg)
      `MODE_SIX: begin
        hcmd = {clean_reg[4], clean_reg[2], clean_reg[0]};
        lcmd = {clean_reg[5], clean_reg[3], clean_reg[1]};
      end
      `MODE_THREE: begin
        hcmd = {clean_reg[4], clean_reg[2], clean_reg[0]};
        lcmd = ~hcmd;
      end
      `MODE_SINGLE: begin
        // dwell does not hold the step, code_reg tracks the pins; phase c low pin never read here
        for (int p = 0; p < 3; p++) begin
          d = drive_of(ent[2*p +: 2]);
          // high side chopped by pwm; active freewheel fills low on pwm off
          hcmd[p] = d[1] & pwm;
          lcmd[p] = d[0] | (d[1] & ~pwm & ~diode_freewheel_cfg);
        end
      end
      default: begin
        hcmd = 3'h0;
        lcmd = 3'h0;
      end
    endcase
    if (!gate_enable_cfg || fault_cause_reg[`FLT_PUMP_UV_BIT]
        || fault_cause_reg[`FLT_PUMP_OV_BIT]) begin
      hcmd = 3'h0;
      lcmd = 3'h0;
    end
    // handshake: a side turns on only once its partner is off
    hi_next = hcmd & ~lcmd & ~lo_reg;
    lo_next = lcmd & ~hcmd & ~hi_reg;
  end

  //////////////////////////////////////////////////////////////////////////////
  // fault flags, set wins over clear
  // a clear in the same cycle as a live fault leaves that flag set, so a
  // persisting condition is never lost; the pin enable follows the flags.
  // the pump regime is a plain window compare on the supply reading.
  logic fault_oe_n_reg, fault_oe_n_next;
  logic [5:0] oc_reg, oc_next;
  logic tripler_reg, tripler_next;
  always_comb begin
    fault_set = '0;
    fault_set[`FLT_OC_BIT] = |sclean_reg[5:0];
    fault_set[`FLT_PUMP_UV_BIT] = sclean_reg[7];
    fault_set[`FLT_PUMP_OV_BIT] = sclean_reg[8];
    fault_set[`FLT_SHOOT_BIT] = |(hcmd & lcmd);
    fault_cause_next = (fault_clear ? '0 : fault_cause_reg) | fault_set;
    fault_oe_n_next = ~|fault_cause_next;
    oc_next = (fault_clear ? 6'h00 : oc_reg) | sclean_reg[5:0];
    tripler_next = (supply_mv >= `PUMP_TRIPLER_MIN_MV)
                   && (supply_mv <= `PUMP_TRIPLER_MAX_MV);
  end
  // gate, fault and pump registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hi_reg <= 3'h0;
      lo_reg <= 3'h0;
      fault_cause_reg <= '0;
      fault_oe_n_reg <= 1'b1;
      oc_reg <= 6'h00;
      tripler_reg <= 1'b1;
    end else begin
      hi_reg <= hi_next;
      lo_reg <= lo_next;
      fault_cause_reg <= fault_cause_next;
      fault_oe_n_reg <= fault_oe_n_next;
      oc_reg <= oc_next;
      tripler_reg <= tripler_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs from flip-flops, except fault_out_n which is tied low
  // the fault pin is open drain: its data is tied low and only the enable
  // moves, so the external pull-up gives the idle high level.
  assign high_gate_out = hi_reg;
  assign low_gate_out = lo_reg;
  assign fault_out_n = 1'b0; // open drain: only ever pulls low
  assign fault_out_oe_n = fault_oe_n_reg;
  assign fault_cause = fault_cause_reg;
  assign overcurrent_status = oc_reg;
  assign pump_tripler = tripler_reg;
  assign phase_state = code_reg;
  assign dwell_active = dwell_reg;
  assign mode_status = mode_reg;
endmodule // gate_drive_pwm_mode_decoder

// File: verif/mode_decoder_chk.sv
`timescale 1ns/1ps
`include "gate_drive_map.svh"
module mode_decoder_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic phase_c_high_in,
  input wire logic gate_enable_cfg,
  input wire logic [5:0] vds_overcurrent_in,
  input wire logic fault_clear,
  input wire logic [2:0] high_gate_out,
  input wire logic [2:0] low_gate_out,
  input wire logic fault_out_oe_n,
  input wire logic [`FLT_WIDTH-1:0] fault_cause,
  input wire logic [5:0] overcurrent_status,
  input wire logic dwell_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // inputs held long enough to pass the pin filter
  sequence s_oc_held; $stable(vds_overcurrent_in) [*7]; endsequence
  sequence s_dwell_held; (dwell_active && phase_c_high_in) [*6]; endsequence
  a_no_shoot: assert property ((high_gate_out & low_gate_out) == 3'h0)
    else $error("both gates of a phase on");
  a_disable_off: assert property ((!gate_enable_cfg) [*3] |-> {high_gate_out, low_gate_out} == 6'h00)
    else $error("gates on while disabled");
  a_fault_pin: assert property ($stable(fault_cause) [*2] |-> fault_out_oe_n == (fault_cause == 4'h0))
    else $error("fault pin disagrees with cause");
  a_oc_sticky: assert property (!$past(fault_clear) && !$past(fault_clear, 2)
    |-> (overcurrent_status & $past(overcurrent_status)) == $past(overcurrent_status))
    else $error("overcurrent flag lost");
  a_oc_set: assert property (s_oc_held |->
    (overcurrent_status & vds_overcurrent_in) == vds_overcurrent_in)
    else $error("overcurrent flag missing");
  a_pump_off: assert property ((fault_cause[2:1] != 2'h0) [*2] |-> {high_gate_out, low_gate_out} == 6'h00)
    else $error("gates on with pump fault");
  a_dwell_hold: assert property (s_dwell_held |=> dwell_active)
    else $error("dwell left early");
  a_dwell_exit: assert property ((!phase_c_high_in) [*7] |-> !dwell_active)
    else $error("dwell not left");
endmodule // mode_decoder_chk
////////////////////////////////////////
bind gate_drive_pwm_mode_decoder mode_decoder_chk u_mode_decoder_chk (.clk(clk), .rst(rst),
  .phase_c_high_in(phase_c_high_in), .gate_enable_cfg(gate_enable_cfg),
  .vds_overcurrent_in(vds_overcurrent_in), .fault_clear(fault_clear),
  .high_gate_out(high_gate_out), .low_gate_out(low_gate_out), .fault_out_oe_n(fault_out_oe_n),
  .fault_cause(fault_cause), .overcurrent_status(overcurrent_status),
  .dwell_active(dwell_active));

// File: verif/mcu_pin_model.sv
`timescale 1ns/1ps
module mcu_pin_model (
  input wire logic clk,
  input wire logic [5:0] raw,
  input wire logic single,
  input wire logic pwm,
  input wire logic [2:0] code,
  input wire logic dwell_req,
  output logic [5:0] pins
);
  logic idle_reg = 1'b0;
  initial pins = 6'h00;
  // gpio port, updates just after the edge; unused pin toggles every cycle
  always @(posedge clk) begin
    idle_reg <= ~idle_reg;
    pins <= single ? {idle_reg, dwell_req, code, pwm} : raw;
  end
endmodule // mcu_pin_model

// File: verif/gate_drive_pwm_mode_decoder_bench.sv
`timescale 1ns/1ps
`include "gate_drive_map.svh"
module gate_drive_pwm_mode_decoder_bench;
  logic clk = 1'b0, rst = 1'b1, dfw = 1'b0, gen = 1'b1, fclr = 1'b0, uv = 1'b0, ov = 1'b0;
  logic single = 1'b0, pwm = 1'b1, dwell = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [2:0] code = 3'h0;
  logic [5:0] raw = 6'h00, vds = 6'h00;
  logic [15:0] supply = 16'h2ee0;
  logic [47:0] atb = {6'h00, 6'h19, 6'h18, 6'h12, 6'h06, 6'h24, 6'h21, 6'h09};
  logic [47:0] dtb = {6'h09, 6'h21, 6'h24, 6'h06, 6'h12, 6'h18, 6'h19, 6'h00};
  logic [5:0] pins, ovc;
  logic [2:0] hi, lo, pst;
  logic [3:0] cause;
  logic [1:0] mst;
  logic oe_n, pin_n, trip, dwa;
  int n_errors = 0;
  int samples_checked = 0;
  // device and pin driver
  gate_drive_pwm_mode_decoder u_gate_drive_pwm_mode_decoder (.clk(clk), .rst(rst),
    .phase_a_high_in(pins[0]), .phase_a_low_in(pins[1]), .phase_b_high_in(pins[2]),
    .phase_b_low_in(pins[3]), .phase_c_high_in(pins[4]), .phase_c_low_in(pins[5]),
    .mode_cfg(mode), .diode_freewheel_cfg(dfw), .gate_enable_cfg(gen), .supply_mv(supply),
    .active_table_cfg(atb), .diode_table_cfg(dtb), .vds_overcurrent_in(vds),
    .pump_uv_in(uv), .pump_ov_in(ov), .fault_clear(fclr), .high_gate_out(hi),
    .low_gate_out(lo), .fault_out_n(pin_n), .fault_out_oe_n(oe_n), .fault_cause(cause),
    .overcurrent_status(ovc), .pump_tripler(trip), .phase_state(pst),
    .dwell_active(dwa), .mode_status(mst));
  mcu_pin_model u_mcu_pin_model (.clk(clk), .raw(raw), .single(single), .pwm(pwm),
    .code(code), .dwell_req(dwell), .pins(pins));
  ////////////////////////////////////////
  // pin model register plus filter and gate register
  task automatic settle();
    repeat (8) @(posedge clk);
    #1;
  endtask
  task automatic check_vec(input logic [5:0] got, input logic [5:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // expected {low, high} gates of one table entry
  function automatic logic [5:0] gates_of(input logic [5:0] e);
    logic [5:0] g;
    for (int k = 0; k < 3; k++) begin
      g[k] = e[2*k+:2] == `DRV_HIGH;
      g[k+3] = e[2*k+:2] == `DRV_LOW;
    end
    return g;
  endfunction
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    forever #5 clk = ~clk;
  end
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    #1;
    check_vec({lo, hi}, 6'h00);
    check_vec({mst, cause}, 6'h00);
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk) raw <= 6'h01 << i;
      settle();
      check_vec({lo, hi}, {raw[5], raw[3], raw[1], raw[4], raw[2], raw[0]});
    end
    @(posedge clk) mode <= `MODE_THREE;
    raw <= 6'h3b;
    settle();
    check_vec({lo, hi}, 6'h15);
    @(posedge clk) raw <= 6'h2a;
    settle();
    check_vec({lo, hi}, 6'h38);
    @(posedge clk) mode <= `MODE_SINGLE;
    single <= 1'b1;
    for (int c = 0; c < 16; c++) begin
      @(posedge clk) dfw <= c[3];
      code <= c[2:0];
      settle();
      check_vec({lo, hi}, gates_of(c[3] ? dtb[6*c[2:0]+:6] : atb[6*c[2:0]+:6]));
      check_vec({4'h0, mst}, 6'h02);
      check_vec({3'h0, pst}, {3'h0, c[2:0]});
    end
    @(posedge clk) pwm <= 1'b0;
    settle();
    check_vec({3'h0, hi}, 6'h00);
    @(posedge clk) pwm <= 1'b1;
    gen <= 1'b0;
    settle();
    check_vec({lo, hi}, 6'h00);
    @(posedge clk) gen <= 1'b1;
    dwell <= 1'b1;
    settle();
    @(posedge clk) code <= 3'h2;
    settle();
    check_vec({5'h0, dwa}, 6'h01);
    @(posedge clk) dwell <= 1'b0;
    settle();
    check_vec({5'h0, dwa}, 6'h00);
    check_vec({lo, hi}, gates_of(dtb[17:12]));
    @(posedge clk) vds <= 6'h21;
    settle();
    @(posedge clk) vds <= 6'h00;
    settle();
    check_vec(ovc, 6'h21);
    check_vec({oe_n, pin_n, cause}, 6'h01);
    @(posedge clk) uv <= 1'b1;
    ov <= 1'b1;
    settle();
    check_vec({lo, hi}, 6'h00);
    check_vec({2'h0, cause}, 6'h07);
    @(posedge clk) uv <= 1'b0;
    ov <= 1'b0;
    settle();
    @(posedge clk) fclr <= 1'b1;
    @(posedge clk) fclr <= 1'b0;
    settle();
    check_vec(ovc, 6'h00);
    check_vec({oe_n, trip, cause}, 6'h30);
    // both sides of phase a requested in six-input mode
    @(posedge clk) single <= 1'b0;
    mode <= `MODE_SIX;
    raw <= 6'h03;
    settle();
    check_vec({lo, hi}, 6'h00);
    check_vec({oe_n, pin_n, cause}, 6'h08);
    // unused mode keeps gates off
    @(posedge clk) mode <= 2'h3;
    raw <= 6'h01;
    settle();
    check_vec({lo, hi}, 6'h00);
    check_vec({4'h0, mst}, 6'h03);
    // pump regime at and beyond the window edges
    @(posedge clk) supply <= 16'h4651;
    settle();
    check_vec({5'h0, trip}, 6'h00);
    @(posedge clk) supply <= 16'h4650;
    settle();
    check_vec({5'h0, trip}, 6'h01);
    @(posedge clk) supply <= 16'h112f;
    settle();
    check_vec({5'h0, trip}, 6'h00);
    @(posedge clk) supply <= 16'h1130;
    settle();
    check_vec({5'h0, trip}, 6'h01);
    summarize();
  end
endmodule // gate_drive_pwm_mode_decoder_bench
